// file: common/ppr_consts.svh
// ppr_consts.svh: offsets, field positions, reset values and timing counts
// assumes: included by bare name from the pulse reference design files
`ifndef PPR_CONSTS_SVH
`define PPR_CONSTS_SVH

// register byte offsets on the apb bus
`define PPR_CTRL 9'h000
`define PPR_SLOW_FILT 9'h004
`define PPR_FAST_FILT 9'h008
`define PPR_POSITION 9'h00C
`define PPR_STATUS 9'h010
`define PPR_MP_WAIT 9'h014
`define PPR_MP_LAST 9'h018
`define PPR_TBL_BIT 8

// ctrl field positions
`define PPR_MODE_LSB 0
`define PPR_SRC_LSB 4
`define PPR_FORM_LSB 8
`define PPR_TERM_BIT 12
`define PPR_RUN_BIT 16
`define PPR_CYC_BIT 17

// field codes
`define PPR_MODE_POS 4'h0
`define PPR_SRC_PULSE 4'h0
`define PPR_SRC_TABLE 4'h1
`define PPR_FLD_ACC 2'h2

// timing, clock 20 MHz
`define PPR_CLK_NS 50
`define PPR_SLOW_MAX_KPPS 200
`define PPR_FAST_MAX_KPPS 4000
`define PPR_SLOW_FILT_NS 500
`define PPR_FAST_FILT_NS 125
`define PPR_SLOW_FILT_RST 8'(`PPR_SLOW_FILT_NS / `PPR_CLK_NS)
`define PPR_FAST_FILT_RST 8'(`PPR_FAST_FILT_NS / `PPR_CLK_NS)
`define PPR_MP_LAST_RST 4'hF

`endif

// file: common/ppr_pkg.sv
// ppr_pkg.sv: types of the position pulse reference block
// assumes: nothing beyond a SystemVerilog compiler
package ppr_pkg;

  // pulse decode forms as coded in pulse_form_select
  typedef enum logic [2:0] {
    PF_DIR_POS = 3'h0,
    PF_DIR_NEG = 3'h1,
    PF_QUAD = 3'h2,
    PF_CW_POS = 3'h3,
    PF_CW_NEG = 3'h4
  } ppr_form_e;

  // stored position sequencer
  typedef enum logic [3:0] {
    SQ_IDLE = 4'b0001,
    SQ_READ = 4'b0010,
    SQ_CAPT = 4'b0100,
    SQ_WAIT = 4'b1000
  } ppr_seq_e;

  // decoded register select
  typedef enum logic [2:0] {
    R_CTRL, R_SLOW, R_FAST, R_POS, R_STAT, R_WAIT, R_LAST, R_NONE
  } ppr_reg_e;

  typedef struct packed {
    logic [3:0] mode;
    logic [3:0] src;
    ppr_form_e form;
    logic term;
    logic run;
    logic cyc;
  } ppr_cfg_s;

  // pulse reference toward the position loop
  typedef struct packed {
    logic step;
    logic dir;
    logic [31:0] count;
  } ppr_ref_s;

  // stored reference toward the position loop
  typedef struct packed {
    logic valid;
    logic [31:0] disp;
    logic [31:0] speed;
    logic [31:0] accdec;
  } ppr_mp_s;

  typedef struct packed {
    logic [3:0][2:0] sync;
    logic [3:0] stab;
    logic [3:0] filt;
    logic [3:0][7:0] fcnt;
    logic [1:0] prev;
    ppr_cfg_s cfg;
    logic [7:0] slow_tf;
    logic [7:0] fast_tf;
    logic [31:0] mp_wait;
    logic [3:0] mp_last;
    logic [1:0] ph;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    ppr_seq_e seq;
    logic [3:0] idx;
    logic [1:0] k;
    logic [31:0] wcnt;
    logic done;
    logic form_bad;
    ppr_ref_s pref;
    ppr_mp_s mp;
  } ppr_st_s;

  typedef struct packed {
    logic [63:0][31:0] word;
    logic [31:0] rdata;
  } ppr_mem_s;

endpackage : ppr_pkg

// file: hw/ppr_table_mem.sv
// ppr_table_mem.sv: 64-word table of stored position references
// assumes: one write and one read port on pclk; read data one cycle later
`timescale 1ns/1ps
`default_nettype none

module ppr_table_mem
  import ppr_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  // write port
  input wire logic we,
  input wire logic [5:0] waddr,
  input wire logic [31:0] wdata,
  // read port
  input wire logic re,
  input wire logic [5:0] raddr,
  output logic [31:0] rdata
);

  ppr_mem_s st;
  ppr_mem_s next_st;

  // write, and read into the output register
  always_comb
  begin
    next_st = st;
    if (we)
    begin
      next_st.word[waddr] = wdata;
    end
    if (re)
    begin
      next_st.rdata = st.word[raddr];
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st <= '0;
    end
    else if (clk_en)
    begin
      st <= next_st;
    end
  end

  assign rdata = st.rdata;

endmodule : ppr_table_mem

`default_nettype wire

// file: hw/ppr_pulse_ref.sv
// ppr_pulse_ref.sv: position reference front end with apb registers
// assumes: pulse pins come asynchronous from line receivers; pclk 20 MHz
//
// Contract
// - control mode zero selects position control and routes the reference
// - source zero takes the reference from the decoded pulse terminals
// - source one takes the reference from the stored position table
// - slow terminals count correctly up to 200 kpps
// - fast terminals resolve pulses up to 4 Mpps
// - host keeps minimum widths 0.125/0.25 us fast, 1 us, 2.5/5 us slow
// - each pulse path has a digital filter, slow and fast set apart
// - filtered signal lags by filter time; shorter pulses are dropped
// - pulse form codes 0 to 4 select the decoding
// - quadrature counts every edge; A leading counts forward
// - sixteen stored references with displacement, speed, ramp time
// - wait between stored positions and switch mode are settable
//
// Implementation choices: register access over APB and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "ppr_consts.svh"

module ppr_pulse_ref
  import ppr_pkg::*;
(
  // clock, reset, enable
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [8:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // pulse terminals after the line receivers
  input wire logic slow_step_input,
  input wire logic slow_direction_input,
  input wire logic fast_step_input,
  input wire logic fast_direction_input,
  // references toward the position loop
  output ppr_ref_s pos_ref,
  output ppr_mp_s mp_ref
);

  // ***************************************************************
  // functions and reset value
  // ***************************************************************

  // filter: follow the input only once it has held tf cycles
  function automatic logic [8:0] filt_step(input logic in, input logic out,
                                           input logic [7:0] cnt, input logic [7:0] tf);
    logic [8:0] r;
    if (in == out)
    begin
      r = {out, 8'h00};
    end
    else if ({1'b0, cnt} + 9'h001 >= {1'b0, tf})
    begin
      r = {in, 8'h00};
    end
    else
    begin
      r = {out, cnt + 8'h01};
    end
    return r;
  endfunction : filt_step

  // register decode, shared by read and write paths
  function automatic ppr_reg_e reg_sel(input logic [8:0] a);
    ppr_reg_e r;
    case (a)
      `PPR_CTRL: r = R_CTRL;
      `PPR_SLOW_FILT: r = R_SLOW;
      `PPR_FAST_FILT: r = R_FAST;
      `PPR_POSITION: r = R_POS;
      `PPR_STATUS: r = R_STAT;
      `PPR_MP_WAIT: r = R_WAIT;
      `PPR_MP_LAST: r = R_LAST;
      default: r = R_NONE;
    endcase
    return r;
  endfunction : reg_sel

  function automatic ppr_st_s rst_val();
    ppr_st_s r;
    r = '0;
    r.seq = SQ_IDLE;
    r.cfg.form = PF_DIR_POS;
    r.slow_tf = `PPR_SLOW_FILT_RST;
    r.fast_tf = `PPR_FAST_FILT_RST;
    r.mp_last = `PPR_MP_LAST_RST;
    return r;
  endfunction : rst_val

  localparam ppr_st_s ST_RST = rst_val();

  // ***************************************************************
  // state and working signals
  // ***************************************************************

  ppr_st_s st;
  ppr_st_s next_st;
  logic [3:0] pins;
  logic [7:0] tf;
  logic acc;
  logic tbl;
  logic apb_mem;
  logic pulse_gate;
  logic table_gate;
  logic a;
  logic b;
  logic pa;
  logic pb;
  logic stp;
  logic fwd;
  ppr_reg_e rsel;
  logic [31:0] rd_val;
  logic mem_we;
  logic mem_re;
  logic [5:0] mem_raddr;
  logic [31:0] mem_rdata;

  assign pins = {fast_direction_input, fast_step_input, slow_direction_input, slow_step_input};

  // ***************************************************************
  // next state
  // ***************************************************************

  always_comb
  begin
    next_st = st;
    tf = 8'h00;
    mem_we = 1'b0;
    mem_re = 1'b0;
    mem_raddr = paddr[7:2];
    acc = psel & penable;
    tbl = paddr[`PPR_TBL_BIT] & (paddr[1:0] == 2'b00);
    rsel = reg_sel(paddr);
    apb_mem = acc && !st.pready && (st.ph == 2'b00) && tbl && !pwrite;
    pulse_gate = (st.cfg.mode == `PPR_MODE_POS) && (st.cfg.src == `PPR_SRC_PULSE);
    table_gate = (st.cfg.mode == `PPR_MODE_POS) && (st.cfg.src == `PPR_SRC_TABLE);

    // read mux
    rd_val = 32'h0000_0000;
    case (rsel)
      R_CTRL:
      begin
        rd_val[`PPR_MODE_LSB +: 4] = st.cfg.mode;
        rd_val[`PPR_SRC_LSB +: 4] = st.cfg.src;
        rd_val[`PPR_FORM_LSB +: 3] = st.cfg.form;
        rd_val[`PPR_TERM_BIT] = st.cfg.term;
        rd_val[`PPR_RUN_BIT] = st.cfg.run;
        rd_val[`PPR_CYC_BIT] = st.cfg.cyc;
      end
      R_SLOW: rd_val[7:0] = st.slow_tf;
      R_FAST: rd_val[7:0] = st.fast_tf;
      R_POS: rd_val = st.pref.count;
      R_STAT: rd_val[7:0] = {st.form_bad, st.done, st.seq != SQ_IDLE, 1'b0, st.idx};
      R_WAIT: rd_val = st.mp_wait;
      R_LAST: rd_val[3:0] = st.mp_last;
      default: rd_val = 32'h0000_0000;
    endcase

    // apb: two wait cycles, so table reads come from a register too
    if (acc && !st.pready)
    begin
      if (st.ph == 2'b00)
      begin
        next_st.ph = 2'b01;
        mem_re = apb_mem;
      end
      else
      begin
        next_st.ph = 2'b00;
        next_st.pready = 1'b1;
        next_st.pslverr = !tbl && (rsel == R_NONE);
        next_st.prdata = pwrite ? 32'h0000_0000 : (tbl ? mem_rdata : rd_val);
      end
    end
    else if (st.pready)
    begin
      next_st.pready = 1'b0;
      next_st.pslverr = 1'b0;
    end

    // writes land on the edge that completes the transfer
    if (st.pready && acc && pwrite)
    begin
      if (tbl)
      begin
        mem_we = 1'b1;
      end
      case (rsel)
        R_CTRL:
        begin
          next_st.cfg.mode = pwdata[`PPR_MODE_LSB +: 4];
          next_st.cfg.src = pwdata[`PPR_SRC_LSB +: 4];
          next_st.cfg.form = ppr_form_e'(pwdata[`PPR_FORM_LSB +: 3]);
          next_st.cfg.term = pwdata[`PPR_TERM_BIT];
          next_st.cfg.run = pwdata[`PPR_RUN_BIT];
          next_st.cfg.cyc = pwdata[`PPR_CYC_BIT];
        end
        R_SLOW: next_st.slow_tf = pwdata[7:0];
        R_FAST: next_st.fast_tf = pwdata[7:0];
        R_WAIT: next_st.mp_wait = pwdata;
        R_LAST: next_st.mp_last = pwdata[3:0];
        default: next_st.mp_last = st.mp_last;
      endcase
    end

    // three-flop sync, then filter; 50 ns steps cover 125 ns widths
    for (int i = 0; i < 4; i++)
    begin
      next_st.sync[i] = {st.sync[i][1:0], pins[i]};
      if (st.sync[i][1] == st.sync[i][2])
      begin
        next_st.stab[i] = st.sync[i][2];
      end
      tf = (i < 2) ? st.slow_tf : st.fast_tf;
      {next_st.filt[i], next_st.fcnt[i]} = filt_step(st.stab[i], st.filt[i],
                                                     st.fcnt[i], tf);
    end

    // decode the selected terminal pair
    a = st.cfg.term ? st.filt[2] : st.filt[0];
    b = st.cfg.term ? st.filt[3] : st.filt[1];
    pa = st.prev[0];
    pb = st.prev[1];
    next_st.prev = {b, a};
    stp = 1'b0;
    fwd = 1'b0;
    next_st.form_bad = 1'b0;
    case (st.cfg.form)
      PF_DIR_POS:
      begin
        stp = a & !pa;
        fwd = b;
      end
      PF_DIR_NEG:
      begin
        stp = !a & pa;
        fwd = !b;
      end
      PF_QUAD:
      begin
        stp = (a ^ pa) ^ (b ^ pb); // both flipping at once is dropped
        fwd = a ^ pb;
      end
      PF_CW_POS:
      begin
        stp = (a & !pa) ^ (b & !pb); // coincident edges cancel
        fwd = a & !pa;
      end
      PF_CW_NEG:
      begin
        stp = (!a & pa) ^ (!b & pb);
        fwd = !a & pa;
      end
      default: next_st.form_bad = 1'b1;
    endcase
    next_st.pref.step = stp && pulse_gate;
    if (stp && pulse_gate)
    begin
      next_st.pref.dir = fwd;
      next_st.pref.count = fwd ? st.pref.count + 32'h0000_0001
                               : st.pref.count - 32'h0000_0001;
    end

    // stored position sequencer; apb reads win the table port
    next_st.mp.valid = 1'b0;
    if (!(st.cfg.run && table_gate))
    begin
      next_st.seq = SQ_IDLE;
      next_st.idx = 4'h0;
      next_st.k = 2'h0;
      next_st.done = 1'b0;
    end
    else
    begin
      case (st.seq)
        SQ_IDLE:
        begin
          if (!st.done)
          begin
            next_st.seq = SQ_READ;
            next_st.k = 2'h0;
          end
        end
        SQ_READ:
        begin
          if (!apb_mem)
          begin
            mem_re = 1'b1;
            mem_raddr = {st.idx, st.k};
            next_st.seq = SQ_CAPT;
          end
        end
        SQ_CAPT:
        begin
          case (st.k)
            2'h0: next_st.mp.disp = mem_rdata;
            2'h1: next_st.mp.speed = mem_rdata;
            default: next_st.mp.accdec = mem_rdata;
          endcase
          if (st.k == `PPR_FLD_ACC)
          begin
            next_st.seq = SQ_WAIT;
            next_st.mp.valid = 1'b1;
            next_st.wcnt = 32'h0000_0000;
          end
          else
          begin
            next_st.k = st.k + 2'h1;
            next_st.seq = SQ_READ;
          end
        end
        SQ_WAIT:
        begin
          if (st.wcnt >= st.mp_wait)
          begin
            next_st.k = 2'h0;
            if (st.idx != st.mp_last)
            begin
              next_st.idx = st.idx + 4'h1;
              next_st.seq = SQ_READ;
            end
            else if (st.cfg.cyc)
            begin
              next_st.idx = 4'h0; // cyclic switch mode
              next_st.seq = SQ_READ;
            end
            else
            begin
              next_st.idx = 4'h0; // single pass: rerun needs run cleared
              next_st.done = 1'b1;
              next_st.seq = SQ_IDLE;
            end
          end
          else
          begin
            next_st.wcnt = st.wcnt + 32'h0000_0001;
          end
        end
        default: next_st.seq = SQ_IDLE;
      endcase
    end
  end

  // ***************************************************************
  // registers and table
  // ***************************************************************

  // clock enable low freezes everything, apb included
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st <= ST_RST;
    end
    else if (clk_en)
    begin
      st <= next_st;
    end
  end

  ppr_table_mem u_table (
    .pclk(pclk),
    .presetn(presetn),
    .clk_en(clk_en),
    .we(mem_we),
    .waddr(paddr[7:2]),
    .wdata(pwdata),
    .re(mem_re),
    .raddr(mem_raddr),
    .rdata(mem_rdata)
  );

  assign prdata = st.prdata;
  assign pready = st.pready;
  assign pslverr = st.pslverr;
  assign pos_ref = st.pref;
  assign mp_ref = st.mp;

  // ***************************************************************
  // assertions
  // ***************************************************************

  // run length of the agreed slow step level, for the lag check
  logic [7:0] ast_hi;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ast_hi <= 8'h00;
    end
    else if (clk_en)
    begin
      ast_hi <= !st.stab[0] ? 8'h00 : ((ast_hi == 8'hFF) ? ast_hi : ast_hi + 8'h01);
    end
  end

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  AST_MODE_GATE: assert property (st.pref.step |-> $past(st.cfg.mode) == `PPR_MODE_POS)
    else $error("pulse step outside position control mode");
  AST_SRC_PULSE: assert property (st.pref.step |-> $past(st.cfg.src) == `PPR_SRC_PULSE)
    else $error("pulse step while table source selected");
  AST_SRC_TABLE: assert property (st.mp.valid && $past(clk_en)
    |-> $past(st.cfg.src) == `PPR_SRC_TABLE && $past(st.seq) == SQ_CAPT)
    else $error("stored reference issued without table source");
  AST_FILT_LAG: assert property ($rose(st.filt[0])
    |-> ast_hi == ((st.slow_tf == 8'h00) ? 8'h01 : st.slow_tf))
    else $error("slow filter lag differs from filter time");
  AST_COUNT: assert property (st.pref.step && $past(clk_en)
    |-> st.pref.count == $past(st.pref.count) + (st.pref.dir ? 32'h1 : 32'hFFFF_FFFF))
    else $error("position count does not follow step and direction");
  AST_QUAD_FWD: assert property (clk_en && pulse_gate && st.cfg.form == PF_QUAD
    && {pa, pb} == 2'b00 && {a, b} == 2'b10 |=> st.pref.step && st.pref.dir)
    else $error("quadrature A-leading edge not counted forward");
  AST_PD_DIR: assert property (clk_en && pulse_gate && st.cfg.form == PF_DIR_POS
    && a && !pa |=> st.pref.step && st.pref.dir == $past(b))
    else $error("pulse and direction sense wrong");
  AST_CW_DOWN: assert property (clk_en && pulse_gate && st.cfg.form == PF_CW_POS
    && b && !pb && !(a && !pa) |=> st.pref.step && !st.pref.dir)
    else $error("counter-clockwise pulse not counted down");
  AST_MP_WAIT: assert property (st.mp.valid && $past(clk_en)
    |-> st.seq == SQ_WAIT && st.wcnt == 32'h0 ##1 !st.mp.valid)
    else $error("stored reference not followed by its wait");

  COV_QUAD: cover property (st.pref.step && st.cfg.form == PF_QUAD && !st.pref.dir);
  COV_CW_NEG: cover property (st.pref.step && st.cfg.form == PF_CW_NEG);
  COV_MP: cover property (st.mp.valid && st.idx == st.mp_last);
  COV_BAD: cover property (st.form_bad);

endmodule : ppr_pulse_ref

`default_nettype wire

// file: tb/ppr_host_model.sv
// ppr_host_model.sv: host pulse source driving one step/direction pin pair
// assumes: pclk comes from the bench; the bench calls the tasks by hierarchy
`timescale 1ns/1ps
`default_nettype none

module ppr_host_model
(
  // clock
  input wire logic pclk,
  // pulse pair
  output logic step_pin,
  output logic dir_pin
);
  logic [1:0] q;

  // quiet pins until the bench picks a form
  initial
  begin
    step_pin = 1'b0;
    dir_pin = 1'b0;
    q = 2'h0;
  end

  // idle levels of each form; quadrature restarts at phase 00
  task idle(input logic [2:0] f);
    step_pin <= (f == 3'h1 || f == 3'h4);
    dir_pin <= (f == 3'h4);
    q = 2'h0;
  endtask : idle

  task hold(input int half);
    repeat (half) @(posedge pclk);
  endtask : hold

  // n counted edges; half must stay above the filter, no faster host exists
  task send(input logic [2:0] f, input int n, input logic fwd, input int half);
    for (int i = 0; i < n; i++)
    begin
      case (f)
        3'h0, 3'h1:
        begin
          dir_pin <= fwd ^ f[0];
          hold(half);
          step_pin <= ~f[0];
          hold(half);
          step_pin <= f[0];
        end
        3'h2:
        begin
          q = fwd ? q + 2'h1 : q - 2'h1;
          step_pin <= q[1] ^ q[0];
          dir_pin <= q[1];
        end
        default:
        begin
          if (fwd)
            step_pin <= (f == 3'h3);
          else
            dir_pin <= (f == 3'h3);
          hold(half);
          step_pin <= (f == 3'h4);
          dir_pin <= (f == 3'h4);
        end
      endcase
      hold(half);
    end
  endtask : send
endmodule : ppr_host_model

`default_nettype wire

// file: tb/tb_top.sv
// tb_top.sv: self-checking bench of the position pulse reference block
// assumes: design and host model compiled first; consts header on the path
`timescale 1ns/1ps
`default_nettype none
`include "ppr_consts.svh"

module tb_top
  import ppr_pkg::*;
();
  logic pclk, presetn, clk_en, psel, penable, pwrite, pready, pslverr;
  logic [8:0] paddr;
  logic [31:0] pwdata, prdata, exp_pos, d;
  logic step_pin, dir_pin, term_fast, e;
  ppr_ref_s pos_ref;
  ppr_mp_s mp_ref;
  int n_fail, checks_done, n_steps;

  always #25 pclk = ~pclk;

  // step pulses last one cycle, so count them at every rising edge
  always @(posedge pclk)
    if (pos_ref.step === 1'b1)
      n_steps <= n_steps + 1;

  ppr_host_model i_ppr_host_model (.pclk(pclk), .step_pin(step_pin), .dir_pin(dir_pin));

  ppr_pulse_ref i_ppr_pulse_ref (
    .pclk(pclk), .presetn(presetn), .clk_en(clk_en),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .slow_step_input(term_fast ? 1'b0 : step_pin),
    .slow_direction_input(term_fast ? 1'b0 : dir_pin),
    .fast_step_input(term_fast ? step_pin : 1'b0),
    .fast_direction_input(term_fast ? dir_pin : 1'b0),
    .pos_ref(pos_ref), .mp_ref(mp_ref));

  // ******************************
  // shared tasks
  // ******************************
  task conclude;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : conclude

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // request held until pready is sampled high at a rising edge
  task automatic apb(input logic [8:0] a, input logic wr, input logic [31:0] wd);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= wr;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    if (n == 50)
    begin
      n_fail++;
      conclude();
    end
    d = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic rd_chk(input logic [8:0] a, input logic [31:0] exp);
    apb(a, 1'b0, 32'h0);
    chk(d, exp);
  endtask : rd_chk

  // pins change to the new idle levels only while decoding is off
  task automatic cfg(input logic [2:0] f, input logic fast, input logic [3:0] md, src);
    apb(`PPR_CTRL, 1'b1, 32'h1);
    term_fast <= fast;
    i_ppr_host_model.idle(f);
    i_ppr_host_model.hold(40);
    apb(`PPR_CTRL, 1'b1, {19'h0, fast, 1'b0, f, src, md});
  endtask : cfg

  task automatic burst(input logic [2:0] f, input int n, input logic fwd, input int h,
                       input int exp_n);
    int s0;
    s0 = n_steps;
    i_ppr_host_model.send(f, n, fwd, h);
    i_ppr_host_model.hold(40);
    chk(32'(n_steps - s0), 32'(exp_n));
  endtask : burst

  // ******************************
  // scenarios
  // ******************************
  task automatic t_reset;
    chk(pos_ref.count, 32'h0);
    rd_chk(`PPR_CTRL, 32'h0);
    rd_chk(`PPR_SLOW_FILT, 32'h0000000A);
    rd_chk(`PPR_FAST_FILT, 32'h00000002);
    rd_chk(`PPR_MP_WAIT, 32'h0);
    rd_chk(`PPR_MP_LAST, 32'h0000000F);
    rd_chk(9'h01C, 32'h0);
    chk(32'(e), 32'h1);
    apb(`PPR_POSITION, 1'b1, 32'h5);
    rd_chk(`PPR_POSITION, 32'h0);
  endtask : t_reset

  task automatic t_forms;
    for (int f = 0; f < 5; f++)
    begin
      cfg(3'(f), 1'b0, 4'h0, 4'h0);
      burst(3'(f), 4, 1'b1, 16, 4);
      burst(3'(f), 1, 1'b0, 16, 1);
      exp_pos = exp_pos + 32'h3;
      rd_chk(`PPR_POSITION, exp_pos);
      chk(32'(pos_ref.dir), 32'h0);
      chk(pos_ref.count, exp_pos);
    end
  endtask : t_forms

  task automatic t_fast;
    cfg(3'h2, 1'b1, 4'h0, 4'h0);
    burst(3'h2, 8, 1'b1, 3, 8);
    exp_pos = exp_pos + 32'h8;
    chk(pos_ref.count, exp_pos);
  endtask : t_fast

  task automatic t_filter;
    cfg(3'h0, 1'b0, 4'h0, 4'h0);
    burst(3'h0, 1, 1'b1, 6, 0);
    apb(`PPR_SLOW_FILT, 1'b1, 32'h3);
    rd_chk(`PPR_SLOW_FILT, 32'h3);
    burst(3'h0, 1, 1'b1, 6, 1);
    burst(3'h0, 1, 1'b1, 2, 0);
    exp_pos = exp_pos + 32'h1;
    chk(pos_ref.count, exp_pos);
  endtask : t_filter

  task automatic t_gate;
    cfg(3'h0, 1'b0, 4'h1, 4'h0);
    burst(3'h0, 2, 1'b1, 16, 0);
    cfg(3'h0, 1'b0, 4'h0, 4'h1);
    burst(3'h0, 2, 1'b1, 16, 0);
    cfg(3'h5, 1'b0, 4'h0, 4'h0);
    burst(3'h0, 2, 1'b1, 16, 0);
    apb(`PPR_STATUS, 1'b0, 32'h0);
    chk(32'(d[7]), 32'h1);
    chk(pos_ref.count, exp_pos);
  endtask : t_gate

  // clock enable low freezes decode and apb; then a reset in mid-run
  task automatic t_freeze;
    cfg(3'h0, 1'b0, 4'h0, 4'h0);
    clk_en <= 1'b0;
    burst(3'h0, 2, 1'b1, 16, 0);
    clk_en <= 1'b1;
    i_ppr_host_model.hold(40);
    chk(pos_ref.count, exp_pos);
    // a frozen access only stretches its wait
    fork
      rd_chk(`PPR_SLOW_FILT, 32'h00000003);
      begin
        @(posedge pclk);
        clk_en <= 1'b0;
        repeat (20) @(posedge pclk);
        clk_en <= 1'b1;
      end
    join
    presetn <= 1'b0;
    @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    exp_pos = 32'h0;
    chk(pos_ref.count, exp_pos);
    rd_chk(`PPR_SLOW_FILT, 32'h0000000A);
  endtask : t_freeze

  // next stored reference pulse, bounded wait
  task automatic wait_mp(output int n);
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (mp_ref.valid !== 1'b1 && n < 200);
    chk(32'(n < 200), 32'h1);
  endtask : wait_mp

  task automatic t_table;
    int n;
    for (int k = 0; k < 6; k++)
      apb(9'(9'h100 + (k / 3) * 16 + (k % 3) * 4), 1'b1, 32'hA0000000 | 32'(k));
    rd_chk(9'h104, 32'hA0000001);
    apb(`PPR_MP_LAST, 1'b1, 32'h1);
    apb(`PPR_MP_WAIT, 1'b1, 32'h5);
    apb(`PPR_CTRL, 1'b1, 32'h00010010);
    for (int en = 0; en < 2; en++)
    begin
      wait_mp(n);
      chk(mp_ref.disp, 32'hA0000000 + 32'(en * 3));
      chk(mp_ref.speed, 32'hA0000001 + 32'(en * 3));
      chk(mp_ref.accdec, 32'hA0000002 + 32'(en * 3));
    end
    chk(32'(n), 32'h0000000C);
    i_ppr_host_model.hold(30);
    apb(`PPR_STATUS, 1'b0, 32'h0);
    chk(32'(d[6]), 32'h1);
    // cyclic switch mode wraps from the last entry back to entry 0
    apb(`PPR_CTRL, 1'b1, 32'h0);
    apb(`PPR_CTRL, 1'b1, 32'h00030010);
    repeat (3) wait_mp(n);
    chk(mp_ref.disp, 32'hA0000000);
    chk(32'(n), 32'h0000000C);
    apb(`PPR_CTRL, 1'b1, 32'h0);
  endtask : t_table

  // main sequence: reset held five cycles, then every scenario in turn
  initial
  begin
    pclk = 1'b0;
    presetn = 1'b0;
    clk_en = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 9'h000;
    pwdata = 32'h0;
    term_fast = 1'b0;
    exp_pos = 32'h0;
    n_fail = 0;
    checks_done = 0;
    n_steps = 0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    t_forms();
    t_fast();
    t_filter();
    t_gate();
    t_freeze();
    t_table();
    conclude();
  end
endmodule : tb_top

`default_nettype wire
